// file: rtl/adcrs_pkg.sv
// Constants and types for the converter result and status register bank.
// Assumes an APB slave on a 32-bit byte address space.
package adcrs_pkg;
   localparam int CHANNEL_COUNT = 12;
   localparam int RESULT_W = 12;
   localparam int CHN_W = 4;
   localparam int RANGE_W = 2;
   localparam int WORD_SHIFT = 2;

   // Register byte addresses
   localparam logic [31:0] SEQB_GLOBAL_ADDR = 32'h4001_c014;
   localparam logic [31:0] CHAN0_ADDR = 32'h4001_c020;
   localparam logic [31:0] CHAN_LAST_ADDR = 32'h4001_c04c;
   localparam logic [31:0] READOUT_CTRL_ADDR = 32'h4001_c100;
   localparam logic [31:0] THR0_ADDR = 32'h4001_c104;
   localparam logic [31:0] THR1_ADDR = 32'h4001_c108;
   localparam logic [31:0] THR_SEL_ADDR = 32'h4001_c10c;
   localparam logic [31:0] FLAG_SUMMARY_ADDR = 32'h4001_c110;

   // Field positions
   localparam int RESULT_LSB = 4;
   localparam int RANGE_LSB = 16;
   localparam int CHN_LSB = 26;
   localparam int OVERRUN_BIT = 30;
   localparam int FRESH_BIT = 31;
   localparam int CTRL_MODE_BIT = 0;
   localparam int CTRL_CC_EN_BIT = 1;
   localparam int CTRL_OVR_EN_BIT = 2;
   localparam int THR_LOW_LSB = 0;
   localparam int THR_HIGH_LSB = 16;
   localparam int SUMMARY_GLOBAL_BIT = 12;

   // Threshold range codes
   localparam logic [1:0] RANGE_INSIDE = 2'h0;
   localparam logic [1:0] RANGE_BELOW = 2'h1;
   localparam logic [1:0] RANGE_ABOVE = 2'h2;

   // Reset values
   localparam logic [11:0] RESULT_RESET = 12'h000;
   localparam logic [11:0] THR_LOW_RESET = 12'h000;
   localparam logic [11:0] THR_HIGH_RESET = 12'hfff;

   typedef enum logic [1:0] {
      ADCRS_PH_IDLE = 2'b01,
      ADCRS_PH_ACCESS = 2'b10
   } adcrs_phase_t;

   typedef struct packed {
      logic fresh;
      logic overrun;
      logic [1:0] range;
      logic [11:0] result;
   } adcrs_chan_t;

   typedef struct packed {
      logic fresh;
      logic overrun;
      logic [1:0] range;
      logic [3:0] source_channel_number;
      logic [11:0] result;
   } adcrs_glob_t;
endpackage

// file: rtl/adcrs_cmp_if.sv
// Carrier between the register bank and its threshold range comparator.
// Assumes both ends sit on the same clock; the path is combinational.
`timescale 1ns/10ps
`default_nettype none
interface adcrs_cmp_if;
   logic [11:0] sample;
   logic [11:0] low;
   logic [11:0] high;
   logic [1:0] range;
   modport requester (output sample, output low, output high, input range);
   modport comparator (input sample, input low, input high, output range);
endinterface
`default_nettype wire

// file: rtl/adcrs_range_cmp.sv
// Threshold range classifier for one conversion sample.
// Assumes thresholds are stable while the sample is presented.
`timescale 1ns/10ps
`default_nettype none
module adcrs_range_cmp
   import adcrs_pkg::*;
(
   adcrs_cmp_if.comparator cmp
);
   always_comb begin
      if (cmp.sample < cmp.low) begin
         cmp.range = RANGE_BELOW;
      end else if (cmp.sample > cmp.high) begin
         cmp.range = RANGE_ABOVE;
      end else begin
         cmp.range = RANGE_INSIDE;
      end
   end
endmodule
`default_nettype wire

// file: rtl/adcrs_bank.sv
// Result and status register bank of the 12-bit converter, APB slave.
// Assumes the conversion engine drives the conv inputs on clk_in,
// one pulse per completed conversion, and an APB master on clk_in.
`timescale 1ns/10ps
`default_nettype none
module adcrs_bank
   import adcrs_pkg::*;
#(
   parameter int CHANNELS = CHANNEL_COUNT
)(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [31:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic conv_valid_in,
   input wire logic conv_seq_b_in,
   input wire logic [3:0] conv_channel_in,
   input wire logic [11:0] conv_result_in,
   output logic seqb_complete_req_out,
   output logic seqb_overrun_req_out
);

   typedef struct packed {
      adcrs_phase_t phase;
      logic pready;
      logic pslverr;
      logic keep;
      logic [31:0] prdata;
      adcrs_glob_t glob;
      adcrs_chan_t [CHANNELS-1:0] chan;
      logic mode;
      logic cc_en;
      logic ovr_en;
      logic [11:0] thr0_low;
      logic [11:0] thr0_high;
      logic [11:0] thr1_low;
      logic [11:0] thr1_high;
      logic [CHANNELS-1:0] thr_sel;
      logic cc_req;
      logic ovr_req;
   } adcrs_state_t;

   adcrs_state_t st;
   adcrs_state_t next_st;

   // Constant reset image: flags clear, thresholds open
   localparam adcrs_state_t RESET_ST = '{
      phase: ADCRS_PH_IDLE,
      glob: '{result: RESULT_RESET, default: '0},
      thr0_low: THR_LOW_RESET,
      thr0_high: THR_HIGH_RESET,
      thr1_low: THR_LOW_RESET,
      thr1_high: THR_HIGH_RESET,
      default: '0
   };

   adcrs_cmp_if cmp_bus ();

   adcrs_range_cmp u_cmp (
      .cmp(cmp_bus.comparator)
   );

   // Channel register decode, used by read, keep and clear paths
   function automatic logic chan_hit(input logic [31:0] a);
      chan_hit = (a >= CHAN0_ADDR) && (a <= CHAN_LAST_ADDR) &&
                 (a[WORD_SHIFT-1:0] == '0);
   endfunction

   function automatic logic [3:0] chan_index(input logic [31:0] a);
      logic [31:0] d;
      d = (a - CHAN0_ADDR) >> WORD_SHIFT;
      chan_index = d[3:0];
   endfunction

   function automatic logic [31:0] chan_word(input adcrs_chan_t c);
      logic [31:0] w;
      w = '0;
      w[RESULT_LSB +: RESULT_W] = c.result;
      w[RANGE_LSB +: RANGE_W] = c.range;
      w[OVERRUN_BIT] = c.overrun;
      w[FRESH_BIT] = c.fresh;
      chan_word = w;
   endfunction

   function automatic logic [31:0] glob_word(input adcrs_glob_t g);
      logic [31:0] w;
      w = '0;
      w[RESULT_LSB +: RESULT_W] = g.result;
      w[RANGE_LSB +: RANGE_W] = g.range;
      w[CHN_LSB +: CHN_W] = g.source_channel_number;
      w[OVERRUN_BIT] = g.overrun;
      w[FRESH_BIT] = g.fresh;
      glob_word = w;
   endfunction

   // Threshold pair picked by the converting channel
   logic pick_pair1;
   always_comb begin
      pick_pair1 = 1'b0;
      for (int i = 0; i < CHANNELS; i++) begin
         if (conv_channel_in == 4'(i)) begin
            pick_pair1 = st.thr_sel[i];
         end
      end
      cmp_bus.sample = conv_result_in;
      cmp_bus.low = pick_pair1 ? st.thr1_low : st.thr0_low;
      cmp_bus.high = pick_pair1 ? st.thr1_high : st.thr0_high;
   end

   logic glob_load;
   logic setup;
   logic done;
   logic rd_clr_glob;
   logic rd_clr_chan;
   logic [3:0] rd_idx;
   logic [3:0] setup_idx;
   logic [31:0] rd_word;
   logic rd_err;
   logic [31:0] summary;
   logic clr_i;
   logic load_i;

   always_comb begin
      next_st = st;
      glob_load = conv_valid_in && conv_seq_b_in;
      setup = psel_in && !penable_in && (st.phase == ADCRS_PH_IDLE);
      done = (st.phase == ADCRS_PH_ACCESS) && psel_in && penable_in;
      rd_idx = chan_index(paddr_in);
      setup_idx = rd_idx;
      clr_i = 1'b0;
      load_i = 1'b0;

      // Flag summary view of all lost flags
      summary = '0;
      for (int i = 0; i < CHANNELS; i++) begin
         summary[i] = st.chan[i].overrun;
      end
      summary[SUMMARY_GLOBAL_BIT] = st.glob.overrun;

      // Read data mux
      rd_word = '0;
      rd_err = 1'b0;
      if (paddr_in == SEQB_GLOBAL_ADDR) begin
         rd_word = glob_word(st.glob);
      end else if (chan_hit(paddr_in)) begin
         for (int i = 0; i < CHANNELS; i++) begin
            if (rd_idx == 4'(i)) begin
               rd_word = chan_word(st.chan[i]);
            end
         end
      end else if (paddr_in == READOUT_CTRL_ADDR) begin
         rd_word[CTRL_MODE_BIT] = st.mode;
         rd_word[CTRL_CC_EN_BIT] = st.cc_en;
         rd_word[CTRL_OVR_EN_BIT] = st.ovr_en;
      end else if (paddr_in == THR0_ADDR) begin
         rd_word[THR_LOW_LSB +: RESULT_W] = st.thr0_low;
         rd_word[THR_HIGH_LSB +: RESULT_W] = st.thr0_high;
      end else if (paddr_in == THR1_ADDR) begin
         rd_word[THR_LOW_LSB +: RESULT_W] = st.thr1_low;
         rd_word[THR_HIGH_LSB +: RESULT_W] = st.thr1_high;
      end else if (paddr_in == THR_SEL_ADDR) begin
         rd_word[CHANNELS-1:0] = st.thr_sel;
      end else if (paddr_in == FLAG_SUMMARY_ADDR) begin
         rd_word = summary;
      end else begin
         rd_err = 1'b1;
      end

      // Bus phase sequencing
      next_st.pready = 1'b0;
      next_st.pslverr = 1'b0;
      case (st.phase)
         ADCRS_PH_IDLE: begin
            if (setup) begin
               next_st.phase = ADCRS_PH_ACCESS;
               next_st.pready = 1'b1;
               next_st.pslverr = rd_err;
               next_st.prdata = pwrite_in ? '0 : rd_word;
               // A load landing on the snapshot edge keeps its flags
               next_st.keep = (glob_load && (paddr_in == SEQB_GLOBAL_ADDR)) ||
                              (conv_valid_in && chan_hit(paddr_in) &&
                               (conv_channel_in == setup_idx));
            end
         end
         ADCRS_PH_ACCESS: begin
            next_st.phase = ADCRS_PH_IDLE;
            next_st.keep = 1'b0;
            if (done && pwrite_in) begin
               if (paddr_in == READOUT_CTRL_ADDR) begin
                  next_st.mode = pwdata_in[CTRL_MODE_BIT];
                  next_st.cc_en = pwdata_in[CTRL_CC_EN_BIT];
                  next_st.ovr_en = pwdata_in[CTRL_OVR_EN_BIT];
               end else if (paddr_in == THR0_ADDR) begin
                  next_st.thr0_low = pwdata_in[THR_LOW_LSB +: RESULT_W];
                  next_st.thr0_high = pwdata_in[THR_HIGH_LSB +: RESULT_W];
               end else if (paddr_in == THR1_ADDR) begin
                  next_st.thr1_low = pwdata_in[THR_LOW_LSB +: RESULT_W];
                  next_st.thr1_high = pwdata_in[THR_HIGH_LSB +: RESULT_W];
               end else if (paddr_in == THR_SEL_ADDR) begin
                  next_st.thr_sel = pwdata_in[CHANNELS-1:0];
               end
            end
         end
         default: begin
            next_st.phase = ADCRS_PH_IDLE;
            next_st.keep = 1'b0;
         end
      endcase

      rd_clr_glob = done && !pwrite_in && !st.keep &&
                    (paddr_in == SEQB_GLOBAL_ADDR);
      rd_clr_chan = done && !pwrite_in && !st.keep && chan_hit(paddr_in);

      // Global register; a load on the clearing edge wins
      next_st.glob.fresh = (st.glob.fresh && !rd_clr_glob) || glob_load;
      next_st.glob.overrun = (st.glob.overrun && !rd_clr_glob) ||
                             (glob_load && st.glob.fresh && !rd_clr_glob);
      if (glob_load) begin
         next_st.glob.result = conv_result_in;
         next_st.glob.source_channel_number = conv_channel_in;
         next_st.glob.range = cmp_bus.range;
      end

      // Channel registers, loaded by any sequence
      for (int i = 0; i < CHANNELS; i++) begin
         clr_i = rd_clr_chan && (rd_idx == 4'(i));
         load_i = conv_valid_in && (conv_channel_in == 4'(i));
         next_st.chan[i].fresh = (st.chan[i].fresh && !clr_i) || load_i;
         next_st.chan[i].overrun = (st.chan[i].overrun && !clr_i) ||
                                   (load_i && st.chan[i].fresh && !clr_i);
         if (load_i) begin
            next_st.chan[i].result = conv_result_in;
            next_st.chan[i].range = cmp_bus.range;
         end
      end

      // Requests follow the flags only in per-conversion mode
      next_st.cc_req = !next_st.mode && next_st.cc_en &&
                       next_st.glob.fresh;
      next_st.ovr_req = !next_st.mode && next_st.ovr_en &&
                        next_st.glob.overrun;
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st <= RESET_ST;
      end else if (ce_in) begin
         st <= next_st;
      end
   end

   assign prdata_out = st.prdata;
   assign pready_out = st.pready;
   assign pslverr_out = st.pslverr;
   assign seqb_complete_req_out = st.cc_req;
   assign seqb_overrun_req_out = st.ovr_req;

endmodule
`default_nettype wire

// file: verification/adcrs_bank_props.sv
// Port-level checker for the converter result register bank.
// Assumes it is bound to adcrs_bank and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module adcrs_bank_props
   import adcrs_pkg::*;
#(
   parameter int CHANNELS = CHANNEL_COUNT
)(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [31:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire logic conv_valid_in,
   input wire logic conv_seq_b_in,
   input wire logic [3:0] conv_channel_in,
   input wire logic [11:0] conv_result_in,
   input wire logic seqb_complete_req_out,
   input wire logic seqb_overrun_req_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   wire logic bus_setup = ce_in && psel_in && !penable_in;
   wire logic seqb_load = conv_valid_in && conv_seq_b_in;
   wire logic chan_read = pready_out && !pwrite_in && paddr_in >= CHAN0_ADDR
      && paddr_in < CHAN0_ADDR + 32'(4 * CHANNELS);

   property p_ready_once; ce_in && pready_out |=> !pready_out; endproperty
   a_ready_once: assert property (p_ready_once) else $error("pready held too long");
   property p_setup_answer; bus_setup |=> pready_out; endproperty
   a_setup_answer: assert property (p_setup_answer) else $error("no ready after setup");
   property p_unmapped;
      bus_setup && (paddr_in[31:4] == 28'h4001c00 || paddr_in == 32'h4001_c010)
      |=> pslverr_out && prdata_out == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
   property p_err_ready; pslverr_out |-> pready_out; endproperty
   a_err_ready: assert property (p_err_ready) else $error("error without ready");
   property p_glob_load; seqb_load ##1 !conv_valid_in ##1 (bus_setup && !pwrite_in && paddr_in == SEQB_GLOBAL_ADDR && !conv_valid_in) |=> prdata_out[31] && prdata_out[29:26] == $past(conv_channel_in, 3) && prdata_out[15:4] == $past(conv_result_in, 3); endproperty
   a_glob_load: assert property (p_glob_load) else $error("global word not from last load");
   property p_cc_rise;
      $rose(seqb_complete_req_out) |-> $past(seqb_load) || $past(psel_in && penable_in && pwrite_in);
   endproperty
   a_cc_rise: assert property (p_cc_rise) else $error("completion request without cause");
   property p_ovr_rise;
      $rose(seqb_overrun_req_out) |-> $past(seqb_load) || $past(psel_in && penable_in && pwrite_in);
   endproperty
   a_ovr_rise: assert property (p_ovr_rise) else $error("overrun request without cause");
   property p_ovr_fall; $fell(seqb_overrun_req_out) |-> $past(psel_in && penable_in); endproperty
   a_ovr_fall: assert property (p_ovr_fall) else $error("overrun request dropped without access");
   property p_no_range3;
      (chan_read || (pready_out && !pwrite_in && paddr_in == SEQB_GLOBAL_ADDR))
      |-> prdata_out[17:16] != 2'h3;
   endproperty
   a_no_range3: assert property (p_no_range3) else $error("range code 3 seen");
   property p_chan_zero; chan_read |-> prdata_out[3:0] == 4'h0 && prdata_out[29:18] == 12'h0; endproperty
   a_chan_zero: assert property (p_chan_zero) else $error("channel word unused bits set");
endmodule
bind adcrs_bank adcrs_bank_props #(.CHANNELS(CHANNELS)) u_props (
   .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .psel_in(psel_in),
   .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
   .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
   .pslverr_out(pslverr_out), .conv_valid_in(conv_valid_in), .conv_seq_b_in(conv_seq_b_in),
   .conv_channel_in(conv_channel_in), .conv_result_in(conv_result_in),
   .seqb_complete_req_out(seqb_complete_req_out), .seqb_overrun_req_out(seqb_overrun_req_out)
);
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench for the converter result register bank.
// Assumes the package, design and checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import adcrs_pkg::*;
;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic ce_in = 1'b1;
   logic psel_in = 1'b0;
   logic penable_in = 1'b0;
   logic pwrite_in = 1'b0;
   logic [31:0] paddr_in = 32'h0;
   logic [31:0] pwdata_in = 32'h0;
   logic conv_valid_in = 1'b0;
   logic conv_seq_b_in = 1'b0;
   logic [3:0] conv_channel_in = 4'h0;
   logic [11:0] conv_result_in = 12'h000;
   logic [31:0] prdata_out;
   logic pready_out, pslverr_out, seqb_complete_req_out, seqb_overrun_req_out;
   logic [31:0] rd;
   logic err;
   logic [11:0] rv [4] = '{12'h0ff, 12'h100, 12'h800, 12'h801};
   logic [1:0] rc [4] = '{2'h1, 2'h0, 2'h0, 2'h2};
   int error_cnt = 0;
   int checked = 0;

   always #12.5 clk_in = ~clk_in;

   adcrs_bank u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
      .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
      .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
      .pready_out(pready_out), .pslverr_out(pslverr_out), .conv_valid_in(conv_valid_in),
      .conv_seq_b_in(conv_seq_b_in), .conv_channel_in(conv_channel_in),
      .conv_result_in(conv_result_in), .seqb_complete_req_out(seqb_complete_req_out),
      .seqb_overrun_req_out(seqb_overrun_req_out));

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
      psel_in <= 1'b1;
      pwrite_in <= wr;
      paddr_in <= addr;
      pwdata_in <= wd;
      @(posedge clk_in);
      penable_in <= 1'b1;
      do begin
         @(posedge clk_in);
      end while (pready_out !== 1'b1);
      rd = prdata_out;
      err = pslverr_out;
      chk("pready", 32'h1, {31'h0, pready_out});
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      @(posedge clk_in);
   endtask

   task automatic rdchk(input string name, input logic [31:0] addr, input logic [31:0] exp,
      input logic [31:0] mask);
      apb(1'b0, addr, 32'h0);
      chk(name, exp & mask, rd & mask);
   endtask

   task automatic conv(input logic [3:0] ch, input logic [11:0] res, input logic seqb);
      conv_valid_in <= 1'b1;
      conv_channel_in <= ch;
      conv_result_in <= res;
      conv_seq_b_in <= seqb;
      @(posedge clk_in);
      conv_valid_in <= 1'b0;
      @(posedge clk_in);
   endtask

   task automatic req(input logic [1:0] exp);
      chk("requests", {30'h0, exp}, {30'h0, seqb_overrun_req_out, seqb_complete_req_out});
   endtask

   function automatic logic [31:0] cw(input logic f, input logic l, input logic [1:0] rg,
      input logic [11:0] r);
      return {f, l, 12'h0, rg, r, 4'h0};
   endfunction

   initial begin
      repeat (5000) @(posedge clk_in);
      error_cnt++;
      report_and_stop();
   end

   initial begin
      repeat (16) @(posedge clk_in);
      rst_n_in <= 1'b1;
      @(posedge clk_in);
      rdchk("glob_flags", SEQB_GLOBAL_ADDR, 32'h0, 32'hc000_0000);
      for (int i = 0; i < 12; i++) begin
         rdchk("chan_reset", CHAN0_ADDR + 32'(4 * i), 32'h0, '1);
      end
      apb(1'b0, 32'h4001_c010, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, err});
      $display("test reset done");
      for (int i = 0; i < 12; i++) begin
         conv(4'(i), {4'(i), 8'h5a}, 1'b0);
      end
      for (int i = 0; i < 12; i++) begin
         rdchk("chan", CHAN0_ADDR + 32'(4 * i), cw(1, 0, 0, {4'(i), 8'h5a}), '1);
         rdchk("chan_again", CHAN0_ADDR + 32'(4 * i), cw(0, 0, 0, {4'(i), 8'h5a}), '1);
      end
      rdchk("glob_flags", SEQB_GLOBAL_ADDR, 32'h0, 32'hc000_0000);
      $display("test channels done");
      apb(1'b1, READOUT_CTRL_ADDR, 32'h6);
      conv(4'h5, 12'habc, 1'b1);
      req(2'b01);
      conv(4'h7, 12'h123, 1'b1);
      req(2'b11);
      rdchk("chan5", CHAN0_ADDR + 32'h14, cw(1, 0, 0, 12'habc), '1);
      req(2'b11);
      rdchk("glob", SEQB_GLOBAL_ADDR, 32'hdc00_1230, 32'hfc03_fff0);
      @(posedge clk_in);
      req(2'b00);
      rdchk("glob_clear", SEQB_GLOBAL_ADDR, 32'h1c00_1230, 32'hfc03_fff0);
      $display("test global done");
      apb(1'b1, READOUT_CTRL_ADDR, 32'h7);
      conv(4'h2, 12'h0ff, 1'b1);
      conv(4'h2, 12'hfff, 1'b1);
      req(2'b00);
      rdchk("summary", FLAG_SUMMARY_ADDR, 32'h1004, '1);
      conv(4'h2, 12'h000, 1'b1);
      rdchk("glob_mode1", SEQB_GLOBAL_ADDR, 32'hc800_0000, 32'hfc03_fff0);
      $display("test mode done");
      apb(1'b1, THR0_ADDR, 32'h0800_0100);
      foreach (rv[k]) begin
         conv(4'h0, rv[k], 1'b0);
         rdchk("range", CHAN0_ADDR, cw(1, 0, rc[k], rv[k]), '1);
      end
      apb(1'b1, THR1_ADDR, 32'h0);
      apb(1'b1, THR_SEL_ADDR, 32'h2);
      conv(4'h1, 12'h001, 1'b0);
      rdchk("range_pair1", CHAN0_ADDR + 32'h4, cw(1, 0, 2'h2, 12'h001), '1);
      $display("test range done");
      ce_in <= 1'b0;
      conv(4'h3, 12'h555, 1'b0);
      ce_in <= 1'b1;
      rdchk("frozen", CHAN0_ADDR + 32'hc, cw(0, 0, 0, 12'h35a), '1);
      apb(1'b1, CHAN0_ADDR + 32'h10, 32'hffff_ffff);
      rdchk("read_only", CHAN0_ADDR + 32'h10, cw(0, 0, 0, 12'h45a), '1);
      $display("test freeze done");
      report_and_stop();
   end
endmodule
`default_nettype wire
